// >>> rtl/lan_eeprom_phy_mgmt_regs.sv
// Register bank for EEPROM port, transceiver management, receive counter and early receive
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module lan_eeprom_phy_mgmt_regs (
	input  wire logic                clk_in,
	input  wire logic                reset_in,
	input  wire logic                enable_in,
	input  wire logic [4:0]          addr_in,
	input  wire logic [3:0]          byte_en_in,
	input  wire logic [31:0]         wdata_in,
	input  wire logic                write_in,
	input  wire logic                read_in,
	output logic      [31:0]         rdata_out,
	input  wire logic                prom_serial_out_pin_in,
	output logic                     prom_serial_in_pin_out,
	output logic                     prom_select_pin_out,
	output logic                     prom_shift_clock_pin_out,
	output logic                     mdc_out,
	input  wire logic                mdio_in,
	output logic                     mdio_out,
	output logic                     mdio_oe_out,
	input  wire logic                rx_byte_valid_in,
	input  wire logic                rx_frame_start_in,
	input  wire logic [15:0]         rx_frame_len_in,
	input  wire logic                rx_frame_end_in,
	output logic                     early_rx_status_flag_out,
	output logic                     mgmt_irq_out,
	output logic                     frame_irq_out
);
	import lan_regs_pkg::*;

	// *************************************************************************
	// Pin synchronisers
	// *************************************************************************
	logic [1:0] prom_serial_out_bit_sync_reg;
	logic [1:0] mdio_sync_reg;

	// Both pins come from outside; second stage is the only reader of the first
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prom_serial_out_bit_sync_reg <= 2'h0;
			mdio_sync_reg <= 2'h0;
		end else if (enable_in) begin
			prom_serial_out_bit_sync_reg <= {prom_serial_out_bit_sync_reg[0], prom_serial_out_pin_in};
			mdio_sync_reg <= {mdio_sync_reg[0], mdio_in};
		end
	end

	// *************************************************************************
	// Register decode
	// *************************************************************************
	wire wr_eeprom = write_in && addr_in == ADDR_EEPROM;
	wire wr_mgmt   = write_in && addr_in == ADDR_MGMT;
	wire wr_thresh = write_in && addr_in == ADDR_THRESH && byte_en_in[0];
	wire launch    = wr_mgmt && byte_en_in[3];

	// Byte-lane merge shared by the command register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// *************************************************************************
	// EEPROM port
	// *************************************************************************
	logic [7:0] eeprom_reg;

	// Pins follow the stored bits straight away; bit 2 is write-only
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			eeprom_reg <= EEPROM_RESET;
		end else if (enable_in && wr_eeprom && byte_en_in[0]) begin
			eeprom_reg <= {5'h00, wdata_in[EE_DI_BIT], wdata_in[PROM_SELECT_PIN_BIT], wdata_in[EE_SK_BIT]};
		end
	end
	assign prom_serial_in_pin_out   = eeprom_reg[EE_DI_BIT];
	assign prom_select_pin_out      = eeprom_reg[PROM_SELECT_PIN_BIT];
	assign prom_shift_clock_pin_out = eeprom_reg[EE_SK_BIT];

	// *************************************************************************
	// Transceiver management
	// *************************************************************************
	logic [31:0]  mgmt_reg;
	logic [31:0]  shadow_reg;
	mgmt_state_t  state_reg;
	logic [7:0]   div_reg;
	logic [5:0]   bit_reg;
	logic [31:0]  shift_reg;
	logic         mdc_reg;
	logic         mdio_o_reg;
	logic         mdio_oe_reg;
	logic         mgmt_irq_reg;

	wire [1:0]  op        = shadow_reg[MG_OP_HI:MG_OP_LO];
	wire        op_valid  = op == OP_WRITE || op == OP_READ;
	wire        is_read   = op == OP_READ;
	wire        busy      = state_reg != MG_IDLE;
	wire        half_tick = div_reg == MDC_HALF_LAST;
	wire        fall      = half_tick && mdc_reg;
	wire        rise      = half_tick && !mdc_reg;
	// Only the last fall of the frame itself ends a transaction, not the end of the preamble
	wire        done      = state_reg == MG_FRAME && fall && bit_reg == 6'h00;
	wire [31:0] wr_merged = merge(mgmt_reg, wdata_in, byte_en_in);
	// Start, opcode, addresses, turnaround and data as one shift word
	wire [31:0] frame_word = {START_BITS, op, shadow_reg[25:21], shadow_reg[20:16],
				TA_WRITE, shadow_reg[MG_DATA_HI:0]};

	// Writes during a transaction are dropped and the register keeps its value; the frame runs from the
	// shadow copy taken at launch, so it cannot be corrupted
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mgmt_reg <= MGMT_RESET;
		end else if (enable_in) begin
			if (done) begin
				mgmt_reg[MG_RDY_BIT] <= 1'b1;
				if (is_read) begin
					mgmt_reg[MG_DATA_HI:0] <= shift_reg[MG_DATA_HI:0];
				end
			end else if (wr_mgmt && !busy) begin
				mgmt_reg <= wr_merged;
			end
		end
	end

	// Frame sequencer: 32 preamble ones, then the 32-bit frame
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_reg   <= MG_IDLE;
			shadow_reg  <= MGMT_RESET;
			div_reg     <= 8'h00;
			bit_reg     <= 6'h00;
			shift_reg   <= 32'h00000000;
			mdc_reg     <= 1'b0;
			mdio_o_reg  <= 1'b0;
			mdio_oe_reg <= 1'b0;
		end else if (enable_in) begin
			div_reg <= (busy && !half_tick) ? div_reg + 8'h01 : 8'h00;
			if (busy && half_tick) begin
				mdc_reg <= !mdc_reg;
			end
			case (state_reg)
				MG_IDLE: begin
					mdc_reg     <= 1'b0;
					mdio_oe_reg <= 1'b0;
					if (launch && wr_merged[MG_OP_HI:MG_OP_LO] inside {OP_WRITE, OP_READ}) begin
						shadow_reg  <= wr_merged;
						state_reg   <= MG_PRE;
						bit_reg     <= FRAME_BITS - 6'h01;
						mdio_o_reg  <= 1'b1;
						mdio_oe_reg <= 1'b1;
					end
				end
				MG_PRE: begin
					if (fall) begin
						if (bit_reg == 6'h00) begin
							state_reg  <= MG_FRAME;
							bit_reg    <= FRAME_BITS - 6'h01;
							shift_reg  <= {frame_word[30:0], 1'b0};
							mdio_o_reg <= frame_word[31];
						end else begin
							bit_reg <= bit_reg - 6'h01;
						end
					end
				end
				MG_FRAME: begin
					if (rise && is_read && bit_reg < TA_BIT - 6'h02) begin
						shift_reg <= {shift_reg[30:0], mdio_sync_reg[1]};
					end
					if (fall) begin
						if (bit_reg == 6'h00) begin
							state_reg   <= MG_IDLE;
							mdio_oe_reg <= 1'b0;
						end else begin
							bit_reg <= bit_reg - 6'h01;
							// Once the line is released the rise edges own the shifter
							if (!(is_read && bit_reg <= TA_BIT)) begin
								mdio_o_reg <= shift_reg[31];
								shift_reg  <= {shift_reg[30:0], 1'b0};
							end
							// Release the line for turnaround and data on reads
							mdio_oe_reg <= !(is_read && bit_reg <= TA_BIT);
						end
					end
				end
				default: state_reg <= MG_IDLE;
			endcase
		end
	end
	assign mdc_out     = mdc_reg;
	assign mdio_out    = mdio_o_reg;
	assign mdio_oe_out = mdio_oe_reg;

	// Completion pulse, gated by the enable bit of the launching command
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mgmt_irq_reg <= 1'b0;
		end else if (enable_in) begin
			mgmt_irq_reg <= done && shadow_reg[MG_IE_BIT];
		end
	end
	assign mgmt_irq_out = mgmt_irq_reg;

	// *************************************************************************
	// Receive byte counter and early receive
	// *************************************************************************
	logic [31:0] rx_bytes_reg;
	logic [7:0]  thresh_reg;
	logic [15:0] remain_reg;
	logic        er_reg;
	logic        frame_irq_reg;

	wire [15:0] thresh_bytes = {5'h00, thresh_reg, 3'h0};              // Quad-words to bytes

	// Counter only wraps; software sees it as free running
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rx_bytes_reg <= 32'h00000000;
		end else if (enable_in && rx_byte_valid_in) begin
			rx_bytes_reg <= rx_bytes_reg + 32'h00000001;
		end
	end

	// Remaining bytes from Type/Length; flag fires once per frame as it crosses x
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			thresh_reg    <= THRESH_RESET;
			remain_reg    <= 16'h0000;
			er_reg        <= 1'b0;
			frame_irq_reg <= 1'b0;
		end else if (enable_in) begin
			if (wr_thresh) begin
				thresh_reg <= wdata_in[7:0];
			end
			er_reg        <= 1'b0;
			frame_irq_reg <= rx_frame_end_in;
			if (rx_frame_start_in) begin
				remain_reg <= rx_frame_len_in;
			end else if (rx_byte_valid_in && remain_reg != 16'h0000) begin
				remain_reg <= remain_reg - 16'h0001;
				er_reg     <= thresh_reg != 8'h00 && remain_reg - 16'h0001 == thresh_bytes;
			end
		end
	end
	assign early_rx_status_flag_out = er_reg;
	assign frame_irq_out            = frame_irq_reg;

	// *************************************************************************
	// Read data, one cycle after the strobe; unmapped reads give zero
	// *************************************************************************
	logic [31:0] rdata_reg;
	wire  [31:0] rd_mux = addr_in == ADDR_EEPROM  ? {28'h0000000, prom_serial_out_bit_sync_reg[1], 1'b0,
				eeprom_reg[PROM_SELECT_PIN_BIT], eeprom_reg[EE_SK_BIT]} :
			addr_in == ADDR_MGMT    ? mgmt_reg :
			addr_in == ADDR_RXBYTES ? rx_bytes_reg :
			addr_in == ADDR_THRESH  ? {24'h000000, thresh_reg} : 32'h00000000;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_reg <= 32'h00000000;
		end else if (enable_in) begin
			rdata_reg <= read_in ? rd_mux : 32'h00000000;
		end
	end
	assign rdata_out = rdata_reg;
endmodule

// >>> rtl/lan_regs_pkg.sv
// Constants for the LAN EEPROM, transceiver management and receive registers
// *****************************************************************************
// *****************************************************************************
package lan_regs_pkg;
	localparam logic [4:0]  ADDR_EEPROM    = 5'h0e;
	localparam logic [4:0]  ADDR_MGMT      = 5'h10;
	localparam logic [4:0]  ADDR_RXBYTES   = 5'h14;
	localparam logic [4:0]  ADDR_THRESH    = 5'h18;
	localparam int          EE_DO_BIT      = 3;
	localparam int          EE_DI_BIT      = 2;
	localparam int          PROM_SELECT_PIN_BIT      = 1;
	localparam int          EE_SK_BIT      = 0;
	localparam int          MG_IE_BIT      = 29;
	localparam int          MG_RDY_BIT     = 28;
	localparam int          MG_OP_HI       = 27;
	localparam int          MG_OP_LO       = 26;
	localparam int          MG_DATA_HI     = 15;
	localparam logic [1:0]  OP_WRITE       = 2'h1;
	localparam logic [1:0]  OP_READ        = 2'h2;
	localparam logic [31:0] MGMT_RESET     = 32'h00000000;
	localparam logic [7:0]  THRESH_RESET   = 8'h00;
	localparam logic [7:0]  EEPROM_RESET   = 8'h00;
	localparam int          CLK_MHZ        = 125;
	localparam int          MDC_HALF_NS    = 200;
	localparam int          MDC_HALF_CYC   = (MDC_HALF_NS * CLK_MHZ) / 1000;
	localparam logic [7:0]  MDC_HALF_LAST  = 8'(MDC_HALF_CYC - 1);
	localparam logic [5:0]  FRAME_BITS     = 6'h20;
	localparam logic [5:0]  TA_BIT         = 6'h12;
	localparam logic [1:0]  START_BITS     = 2'h1;
	localparam logic [1:0]  TA_WRITE       = 2'h2;
	typedef enum logic [1:0] {MG_IDLE, MG_PRE, MG_FRAME} mgmt_state_t;
endpackage

// >>> bench/lan_regs_chk.sv
// Port assertions for the LAN register bank
`timescale 1ns/1ps
module lan_regs_chk (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic        enable_in,
	input wire logic [4:0]  addr_in,
	input wire logic [3:0]  byte_en_in,
	input wire logic [31:0] wdata_in,
	input wire logic        write_in,
	input wire logic        read_in,
	input wire logic [31:0] rdata_out,
	input wire logic        prom_serial_out_pin_in,
	input wire logic        prom_serial_in_pin_out,
	input wire logic        prom_select_pin_out,
	input wire logic        prom_shift_clock_pin_out,
	input wire logic        mdc_out,
	input wire logic        rx_frame_end_in,
	input wire logic        early_rx_status_flag_out,
	input wire logic        mgmt_irq_out,
	input wire logic        frame_irq_out
);
	import lan_regs_pkg::*;
	logic [7:0] thr_reg;
	logic       ie_reg;
	// Only full-word EEPROM and threshold writes are modelled; management writes need only lane 3
	wire        ee_wr = write_in && enable_in && addr_in == ADDR_EEPROM && byte_en_in == 4'hf;
	wire        mg_wr = write_in && enable_in && addr_in == ADDR_MGMT && byte_en_in[3];
	// Shadow copies of the threshold and interrupt enable
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			thr_reg <= 8'h00;
			ie_reg  <= 1'b0;
		end else begin
			if (write_in && enable_in && addr_in == ADDR_THRESH && byte_en_in == 4'hf)
				thr_reg <= wdata_in[7:0];
			if (mg_wr)
				ie_reg <= wdata_in[MG_IE_BIT];
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ************************************************
	// Checks
	// ************************************************
	prom_select_a: assert property (ee_wr |=> prom_select_pin_out == $past(wdata_in[PROM_SELECT_PIN_BIT]))
		else $error("select pin differs from written bit");
	prom_data_a: assert property (ee_wr |=> prom_serial_in_pin_out == $past(wdata_in[EE_DI_BIT]))
		else $error("data pin differs from written bit");
	prom_clock_a: assert property (ee_wr |=> prom_shift_clock_pin_out == $past(wdata_in[EE_SK_BIT]))
		else $error("clock pin differs from written bit");
	data_out_a: assert property (($stable(prom_serial_out_pin_in) [*4]) ##0
		(read_in && enable_in && addr_in == ADDR_EEPROM) |=> rdata_out[EE_DO_BIT] == $past(prom_serial_out_pin_in))
		else $error("data out bit differs from pin");
	mdc_half_a: assert property ($rose(mdc_out) |-> ##[24:26] $fell(mdc_out))
		else $error("management clock half period wrong");
	irq_enable_a: assert property (mgmt_irq_out |-> ie_reg)
		else $error("management interrupt while disabled");
	irq_pulse_a: assert property (mgmt_irq_out |=> !mgmt_irq_out)
		else $error("management interrupt longer than a pulse");
	early_off_a: assert property (early_rx_status_flag_out |-> thr_reg != 8'h00)
		else $error("early receive flag with zero threshold");
	frame_irq_a: assert property (rx_frame_end_in && enable_in |-> ##[0:2] frame_irq_out)
		else $error("no end of frame interrupt");
	cover property (mgmt_irq_out);
	cover property (early_rx_status_flag_out);
	cover property (frame_irq_out);
endmodule
bind lan_eeprom_phy_mgmt_regs lan_regs_chk lan_regs_chk_inst (.clk_in, .reset_in, .enable_in, .addr_in,
	.byte_en_in, .wdata_in, .write_in, .read_in, .rdata_out, .prom_serial_out_pin_in, .prom_serial_in_pin_out,
	.prom_select_pin_out, .prom_shift_clock_pin_out, .mdc_out, .rx_frame_end_in, .early_rx_status_flag_out,
	.mgmt_irq_out, .frame_irq_out);

// >>> bench/phy_model.sv
// Behavioural transceiver on the management clock and data line
`timescale 1ns/1ps
module phy_model (
	input  wire logic   mdc_in,
	input  wire logic   mdio_dev_in,
	input  wire logic   mdio_oe_in,
	output logic        mdio_wire_out,
	output logic [31:0] frame_out,
	output int          frames_out
);
	logic [31:0] fr = '0;
	logic [15:0] rd = '0;
	logic        drv = 1'b0;
	logic        bitv = 1'b1;
	logic        isrd = 1'b0;
	int          n = -1;
	int          ones = 0;
	// A released line floats to its pull-up
	assign mdio_wire_out = mdio_oe_in ? mdio_dev_in : (drv ? bitv : 1'b1);
	initial frames_out = 0;
	// Sample on the rising clock; a frame opens at the first zero after 32 ones
	always @(posedge mdc_in) begin
		if (n < 0) begin
			if (!mdio_wire_out && ones >= 32)
				n = 0;
			ones = mdio_wire_out ? ones + 1 : 0;
		end else
			n = n + 1;
		if (n >= 0)
			fr = {fr[30:0], mdio_wire_out};
		if (n == 13) begin
			isrd = fr[11:10] == 2'b10;
			rd = {fr[9:5], fr[4:0], 6'h2d};
		end
		if (n == 31) begin
			frame_out = fr;
			frames_out++;
			n = -1;
			ones = 0;
		end
	end
	// Answer a read: low second turnaround bit, then data MSB first, then let go
	always @(negedge mdc_in) begin
		drv = isrd && n >= 14 && n <= 30;
		bitv = (n == 14) ? 1'b0 : rd[30 - n];
	end
endmodule

// >>> bench/lan_eeprom_phy_mgmt_regs_test.sv
// Self-checking bench for the LAN register bank
`timescale 1ns/1ps
module lan_eeprom_phy_mgmt_regs_test;
	import lan_regs_pkg::*;
	logic        clk_in, reset_in, enable_in, write_in, read_in, pin_do, rx_v, rx_s, rx_e, pend;
	logic        sel, sdi, sck, mdc, mdio_w, mdio_o, mdio_oe, erf, mirq, firq;
	logic [4:0]  addr_in;
	logic [3:0]  be;
	logic [7:0]  b;
	logic [31:0] wd, rdata, pframe, c, rq[$], fq[$];
	logic [15:0] rx_len;
	int          err_count, checks_done, nmirq, nfirq, nmdc, nfr, lastf, sent, fbyte, m0, x, t, seed;
	localparam logic [4:0] ADDR_LIST [5] = '{ADDR_EEPROM, ADDR_MGMT, ADDR_RXBYTES, ADDR_THRESH, 5'h04};
	lan_eeprom_phy_mgmt_regs lan_eeprom_phy_mgmt_regs_inst (.clk_in, .reset_in, .enable_in, .addr_in,
		.byte_en_in(be), .wdata_in(wd), .write_in, .read_in, .rdata_out(rdata), .prom_serial_out_pin_in(pin_do),
		.prom_serial_in_pin_out(sdi), .prom_select_pin_out(sel), .prom_shift_clock_pin_out(sck), .mdc_out(mdc),
		.mdio_in(mdio_w), .mdio_out(mdio_o), .mdio_oe_out(mdio_oe), .rx_byte_valid_in(rx_v), .rx_frame_start_in(rx_s),
		.rx_frame_len_in(rx_len), .rx_frame_end_in(rx_e), .early_rx_status_flag_out(erf), .mgmt_irq_out(mirq),
		.frame_irq_out(firq));
	phy_model phy_model_inst (.mdc_in(mdc), .mdio_dev_in(mdio_o), .mdio_oe_in(mdio_oe), .mdio_wire_out(mdio_w),
		.frame_out(pframe), .frames_out(nfr));
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (exp !== got) begin
			err_count++;
			$display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [3:0] l, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		be <= l;
		wd <= d;
		write_in <= 1'b1;
		@(posedge clk_in);
		write_in <= 1'b0;
	endtask
	// The expected read value is left as a note for the monitor
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk_in);
		addr_in <= a;
		read_in <= 1'b1;
		@(posedge clk_in);
		read_in <= 1'b0;
		rq.push_back(e);
	endtask
	// Three idle cycles between bytes keep the byte count steady when the flag is seen
	task automatic frame(input int len);
		@(posedge clk_in);
		rx_s <= 1'b1;
		rx_len <= 16'(len);
		@(posedge clk_in);
		rx_s <= 1'b0;
		repeat (len) begin
			rx_v <= 1'b1;
			sent++;
			@(posedge clk_in);
			rx_v <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
		rx_e <= 1'b1;
		@(posedge clk_in);
		rx_e <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic test_done();
		$display("Counts: %0d compares, %0d mismatches", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Monitor: pairs each result with the oldest note
	always @(posedge clk_in) begin
		if (pend)
			chk(rq.pop_front(), rdata);
		pend <= read_in && enable_in;
		if (nfr != lastf) begin
			lastf = nfr;
			chk(fq.pop_front(), pframe);
		end
		if (erf)
			fbyte = sent;
		nmirq += int'(mirq);
		nfirq += int'(firq);
	end
	always @(posedge mdc) nmdc++;
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	initial begin
		repeat (60000) @(posedge clk_in);
		err_count++;
		test_done();
	end
	initial begin
		{reset_in, enable_in, write_in, read_in, pin_do, rx_v, rx_s, rx_e, pend} = 9'h180;
		{addr_in, be, wd, rx_len} = '0;
		seed = 32'h21b9;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		foreach (ADDR_LIST[i]) rd(ADDR_LIST[i], 32'h0);
		$display("reset values done");
		repeat (4) begin
			b = 8'($random(seed));
			wr(ADDR_EEPROM, 4'hf, {4{b}});
			pin_do <= b[7];
			repeat (4) @(posedge clk_in);
			rd(ADDR_EEPROM, {28'h0, b[7], 1'b0, b[1:0]});
		end
		wr(ADDR_EEPROM, 4'hf, 32'h0);
		repeat (130) @(posedge clk_in);
		$display("eeprom port done");
		b = 8'($random(seed));
		wr(ADDR_THRESH, 4'hf, {4{b}});
		enable_in <= 1'b0;
		wr(ADDR_THRESH, 4'hf, 32'h0);
		enable_in <= 1'b1;
		rd(ADDR_THRESH, {24'h0, b});
		x = ($random(seed) & 3) + 1;
		wr(ADDR_THRESH, 4'hf, {4{8'(x)}});
		frame(40);
		chk(32'(fbyte), 32'(40 - 8 * x));
		wr(ADDR_THRESH, 4'hf, 32'h0);
		frame(40);
		chk(32'(fbyte), 32'(40 - 8 * x));
		chk(32'(nfirq), 32'h2);
		rd(ADDR_RXBYTES, 32'd80);
		$display("receive side done");
		c = {4'h2, OP_WRITE, 26'($random(seed))};
		fq.push_back({2'b01, OP_WRITE, c[25:16], 2'b10, c[15:0]});
		wr(ADDR_MGMT, 4'hf, c);
		repeat (200) @(posedge clk_in);
		wr(ADDR_MGMT, 4'hf, c ^ 32'h00ff_ffff);
		for (t = 0; t < 6000 && nmirq == 0; t++) @(posedge clk_in);
		chk(32'(nmirq), 32'h1);
		rd(ADDR_MGMT, c | 32'h1000_0000);
		c = {4'h0, OP_READ, 26'($random(seed))};
		m0 = nmdc;
		wr(ADDR_MGMT, 4'h3, c);
		wr(ADDR_MGMT, 4'h4, c);
		repeat (40) @(posedge clk_in);
		chk(32'(nmdc), 32'(m0));
		fq.push_back({2'b01, OP_READ, c[25:16], 2'b10, c[25:16], 6'h2d});
		wr(ADDR_MGMT, 4'h8, c);
		for (t = 0; t < 6000 && fq.size() > 0; t++) @(posedge clk_in);
		repeat (80) @(posedge clk_in);
		chk(32'(nmirq), 32'h1);
		rd(ADDR_MGMT, {c[31:16] | 16'h1000, c[25:16], 6'h2d});
		for (int i = 0; i < 2; i++) begin
			m0 = nmdc;
			wr(ADDR_MGMT, 4'hf, {4'h0, i ? 2'b11 : 2'b00, 26'h3ff_ffff});
			repeat (100) @(posedge clk_in);
			chk(32'(nmdc), 32'(m0));
		end
		$display("management done");
		repeat (3) @(posedge clk_in);
		test_done();
	end
endmodule
